// ### eac_top.sv
// eeprom access control: i/o registers, write timing, stalls, ready irq
// Functional notes
// - control bits seven to four read zero
// - ready irq needs enable and global enable
// - irq held while write strobe reads zero
// - strobe within four cycles of enable writes
// - strobe ignored without master write enable
// - master enable self clears after four cycles
// - write strobe stays set during programming
// - write strobe cleared when write completes
// - write start stalls core two cycles
// - data register holds the read byte two cycles after the strobe is taken
// - read stalls core four cycles
// - no reads, no address change while busy
// - no write start during flash self programming
// - write lasts 8448 ticks of 1 mhz
// - write finishes in power down, oscillator runs
// - write finishes across a system reset
// - nine bit linear address, upper bits zero
// - data register feeds writes, receives reads
`timescale 1ns/100ps
`default_nettype none
`include "eac_defines.svh"
module eac_top
    import eac_pkg::*;
#(
    parameter int unsigned WRITE_OSC_CYCLES = `EAC_WRITE_OSC_CYCLES
) (
    // clock and resets
    input wire logic clock,
    input wire logic rst,
    input wire logic por_rst,
    // i/o register port of the core
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    output logic [7:0] io_rdata,
    // core interaction
    input wire logic global_irq_enable,
    input wire logic self_program_enable,
    output logic cpu_stall,
    output logic ready_irq,
    // power management
    output logic osc_keep_running
);
    // ---------------------------------------------------------------
    // state and internal links
    // ---------------------------------------------------------------
    eac_ctrl_state_type s_q; // registered state
    eac_ctrl_state_type s_d; // next state
    eac_nvm_if nvm (); // link to the cell array
    logic busy; // write in progress
    logic wr_done; // write time elapsed
    logic ctrl_wr; // core writes the control register
    logic start; // accepted write strobe
    logic rd_acc; // accepted read strobe
    logic write_strobe; // visible write strobe bit

    // ---------------------------------------------------------------
    // register read mux
    // ---------------------------------------------------------------
    function automatic logic [7:0] reg_read(
        input logic [5:0] a,
        input eac_ctrl_state_type st,
        input logic ws
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `EAC_OFS_CTRL: begin
                v = {`EAC_CTRL_RSV, st.rie, st.mwe, ws, 1'b0};
            end
            `EAC_OFS_DATA: begin
                v = st.data;
            end
            `EAC_OFS_ADDRL: begin
                v = st.addr[7:0];
            end
            `EAC_OFS_ADDRH: begin
                v = {`EAC_ADDRH_RSV, st.addr[`EAC_ADDR_W-1]};
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    // ---------------------------------------------------------------
    // request decode
    // ---------------------------------------------------------------
    // the strobe only counts inside the open enable window
    always_comb begin
        write_strobe = busy;
        ctrl_wr = io_we && (io_addr == `EAC_OFS_CTRL);
        start = ctrl_wr && io_wdata[`EAC_BIT_WS] && s_q.mwe
            && !busy && !self_program_enable;
        rd_acc = ctrl_wr && io_wdata[`EAC_BIT_RE] && !busy && !start;
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rd_pend = rd_acc;
        // interrupt enable follows every control write
        if (ctrl_wr) begin
            s_d.rie = io_wdata[`EAC_BIT_RIE];
        end
        // master write enable window
        if (start) begin
            s_d.mwe = 1'b0;
            s_d.mwe_cnt = '0;
        end else if (ctrl_wr && io_wdata[`EAC_BIT_MWE]) begin
            s_d.mwe = 1'b1;
            s_d.mwe_cnt = `EAC_MWE_WINDOW;
        end else if (ctrl_wr) begin
            s_d.mwe = 1'b0;
            s_d.mwe_cnt = '0;
        end else if (s_q.mwe) begin
            s_d.mwe_cnt = s_q.mwe_cnt - 3'h1;
            if (s_q.mwe_cnt == 3'h1) begin
                s_d.mwe = 1'b0;
            end
        end
        // address frozen while a write runs
        if (io_we && !busy) begin
            if (io_addr == `EAC_OFS_ADDRL) begin
                s_d.addr[7:0] = io_wdata;
            end else if (io_addr == `EAC_OFS_ADDRH) begin
                s_d.addr[`EAC_ADDR_W-1] = io_wdata[0];
            end
        end
        // data register: core write, or byte fetched by a read
        if (s_q.rd_pend) begin
            s_d.data = nvm.rdata;
        end else if (io_we && (io_addr == `EAC_OFS_DATA)) begin
            s_d.data = io_wdata;
        end
        // core stall counter
        if (start) begin
            s_d.stall_cnt = `EAC_WR_STALL;
        end else if (rd_acc) begin
            s_d.stall_cnt = `EAC_RD_STALL;
        end else if (s_q.stall_cnt != 3'h0) begin
            s_d.stall_cnt = s_q.stall_cnt - 3'h1;
        end
        // read data held until the next read
        if (io_re) begin
            s_d.io_rdata = reg_read(io_addr, s_q, write_strobe);
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // write timer and cell array
    // ---------------------------------------------------------------
    // timer runs on the power-on reset only, so a write survives rst
    eac_write_timer #(
        .WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)
    ) u_timer (
        .clock(clock),
        .por_rst(por_rst),
        .start(start),
        .busy(busy),
        .done(wr_done)
    );

    assign nvm.addr = s_q.addr;
    assign nvm.wdata = s_q.data;
    assign nvm.wr_start = start;
    assign nvm.wr_done = wr_done;
    assign nvm.rd_en = rd_acc;

    eac_cell_array u_array (
        .clock(clock),
        .nvm(nvm)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign io_rdata = s_q.io_rdata;
    assign cpu_stall = (s_q.stall_cnt != 3'h0);
    // level, not pulse: stays up as long as nothing is programming
    assign ready_irq = s_q.rie && global_irq_enable && !write_strobe;
    // the oscillator cannot stop until the write time has elapsed
    assign osc_keep_running = busy;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence seq_wr_stall;
        cpu_stall [*2] ##1 !cpu_stall;
    endsequence

    sequence seq_rd_stall;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence

    sequence seq_mwe_quiet;
        $rose(s_q.mwe) ##0 !ctrl_wr [*4];
    endsequence

    // a fresh enable, left alone, still admits the strobe on its fourth cycle
    sequence seq_mwe_arm;
        ctrl_wr && io_wdata[`EAC_BIT_MWE] && !start ##1 !ctrl_wr [*3];
    endsequence

    AST_RSV_ZERO: assert property (@(posedge clock) disable iff (rst)
        io_re && io_addr == `EAC_OFS_CTRL |=> io_rdata[7:4] == 4'h0)
        else $error("reserved control bits read nonzero");

    AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (rst)
        s_q.rie && global_irq_enable && !busy |-> ready_irq)
        else $error("ready irq missing while idle and enabled");

    AST_IRQ_GATED: assert property (@(posedge clock) disable iff (rst)
        ready_irq |-> s_q.rie && global_irq_enable && !busy)
        else $error("ready irq without enables");

    AST_MWE_TIMEOUT: assert property (@(posedge clock) disable iff (rst)
        seq_mwe_quiet |=> !s_q.mwe)
        else $error("master write enable did not time out");

    AST_NO_START_CLOSED: assert property (@(posedge clock) disable iff (rst)
        start |-> s_q.mwe && !self_program_enable && !busy)
        else $error("write started without open window");

    AST_WS_HELD: assert property (@(posedge clock) disable iff (rst || por_rst)
        start |=> busy [*8])
        else $error("write strobe dropped early");

    AST_WR_STALL: assert property (@(posedge clock) disable iff (rst)
        start |=> seq_wr_stall)
        else $error("write stall not two cycles");

    AST_RD_STALL: assert property (@(posedge clock) disable iff (rst)
        rd_acc |=> seq_rd_stall)
        else $error("read stall not four cycles");

    AST_RD_DATA: assert property (@(posedge clock) disable iff (rst)
        rd_acc |-> ##2 s_q.data == $past(nvm.rdata))
        else $error("read byte not in data register");

    AST_ADDR_FROZEN: assert property (@(posedge clock) disable iff (rst)
        busy |=> $stable(s_q.addr))
        else $error("address changed during write");

    AST_NO_READ_BUSY: assert property (@(posedge clock) disable iff (rst)
        busy |-> !rd_acc && !start)
        else $error("access accepted during write");

    AST_MWE_WINDOW: assert property (@(posedge clock) disable iff (rst)
        seq_mwe_arm |=> s_q.mwe)
        else $error("master write enable closed before four cycles");

    AST_START_BUSY: assert property (@(posedge clock) disable iff (rst || por_rst)
        start |=> busy)
        else $error("accepted strobe did not start a write");

    AST_CLOSED_NO_WRITE: assert property (@(posedge clock) disable iff (rst || por_rst)
        !s_q.mwe && !busy |=> !busy)
        else $error("write began with master enable clear");

    AST_WS_READBACK: assert property (@(posedge clock) disable iff (rst)
        io_re && io_addr == `EAC_OFS_CTRL && busy |=> io_rdata[`EAC_BIT_WS])
        else $error("write strobe read zero during a write");

    AST_DONE_IDLE: assert property (@(posedge clock) disable iff (rst || por_rst)
        wr_done |-> !write_strobe)
        else $error("write strobe still set after write time");

    AST_STALL_QUIET: assert property (@(posedge clock) disable iff (rst)
        !cpu_stall && !start && !rd_acc |=> !cpu_stall)
        else $error("core stalled without an access");

    AST_SPM_BLOCKS: assert property (@(posedge clock) disable iff (rst || por_rst)
        self_program_enable && !busy |=> !busy)
        else $error("write began during flash self programming");

    AST_RIE_WRITE: assert property (@(posedge clock) disable iff (rst)
        ctrl_wr |=> s_q.rie == $past(io_wdata[`EAC_BIT_RIE]))
        else $error("ready irq enable did not follow control write");

    AST_ADDRH_RSV: assert property (@(posedge clock) disable iff (rst)
        io_re && io_addr == `EAC_OFS_ADDRH |=> io_rdata[7:1] == 7'h00)
        else $error("reserved address bits read nonzero");
endmodule
`default_nettype wire

// ### eac_defines.svh
// constants for the eeprom access control block
`ifndef EAC_DEFINES_SVH
`define EAC_DEFINES_SVH

// ---------------------------------------------------------------
// i/o register offsets
// ---------------------------------------------------------------
`define EAC_OFS_CTRL 6'h1c
`define EAC_OFS_DATA 6'h1d
`define EAC_OFS_ADDRL 6'h1e
`define EAC_OFS_ADDRH 6'h1f

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define EAC_BIT_RIE 3
`define EAC_BIT_MWE 2
`define EAC_BIT_WS 1
`define EAC_BIT_RE 0
`define EAC_CTRL_RSV 4'h0

// ---------------------------------------------------------------
// sizes and timing
// ---------------------------------------------------------------
`define EAC_ADDR_W 9
`define EAC_ADDRH_W 1
`define EAC_ADDRH_RSV 7'h00
`define EAC_MEM_BYTES 512
`define EAC_MWE_WINDOW 3'h4
`define EAC_WR_STALL 3'h2
`define EAC_RD_STALL 3'h4
`define EAC_CLK_HZ 10000000
`define EAC_OSC_HZ 1000000
`define EAC_OSC_DIV (`EAC_CLK_HZ / `EAC_OSC_HZ)
`define EAC_WRITE_OSC_CYCLES 8448
`define EAC_WRITE_TYP_US 8500
`define EAC_DIV_W 4
`define EAC_CNT_W 14

`endif

// ### eac_pkg.sv
// types shared by the eeprom access control modules
package eac_pkg;
`include "eac_defines.svh"

    // write engine phase
    typedef enum logic [0:0] {
        EAC_IDLE,
        EAC_PROG
    } eac_phase_type;

    // write engine state
    typedef struct packed {
        eac_phase_type phase;
        logic [`EAC_DIV_W-1:0] div;
        logic [`EAC_CNT_W-1:0] cnt;
        logic done;
    } eac_timer_state_type;

    // cell array side state
    typedef struct packed {
        logic [`EAC_ADDR_W-1:0] pend_addr;
        logic [7:0] pend_data;
        logic [7:0] rdata;
    } eac_array_state_type;

    // register side state
    typedef struct packed {
        logic rie;
        logic mwe;
        logic [2:0] mwe_cnt;
        logic [`EAC_ADDR_W-1:0] addr;
        logic [7:0] data;
        logic [2:0] stall_cnt;
        logic rd_pend;
        logic [7:0] io_rdata;
    } eac_ctrl_state_type;

endpackage

// ### eac_nvm_if.sv
// link between the register side and the cell array
`timescale 1ns/100ps
`default_nettype none
`include "eac_defines.svh"
interface eac_nvm_if;
    import eac_pkg::*;
    logic [`EAC_ADDR_W-1:0] addr; // selected byte
    logic [7:0] wdata; // byte to program
    logic wr_start; // pulse: latch a write
    logic wr_done; // pulse: write time elapsed
    logic rd_en; // pulse: fetch a byte
    logic [7:0] rdata; // fetched byte, a cycle later
    modport ctrl (output addr, wdata, wr_start, wr_done, rd_en, input rdata);
    modport array (input addr, wdata, wr_start, wr_done, rd_en, output rdata);
endinterface
`default_nettype wire

// ### eac_write_timer.sv
// write duration timer on the 1 mhz tick derived from the core clock
`timescale 1ns/100ps
`default_nettype none
`include "eac_defines.svh"
module eac_write_timer
    import eac_pkg::*;
#(
    parameter int unsigned WRITE_OSC_CYCLES = `EAC_WRITE_OSC_CYCLES
) (
    // clock and power-on reset
    input wire logic clock,
    input wire logic por_rst,
    // control
    input wire logic start,
    output logic busy,
    output logic done
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    eac_timer_state_type s_q; // registered state
    eac_timer_state_type s_d; // next state

    // counts 1 mhz ticks; starts ignored while busy
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.phase)
            EAC_IDLE: begin
                if (start) begin
                    s_d.phase = EAC_PROG;
                    s_d.div = '0;
                    s_d.cnt = '0;
                end
            end
            EAC_PROG: begin
                if (s_q.div == `EAC_DIV_W'(`EAC_OSC_DIV - 1)) begin
                    s_d.div = '0;
                    if (s_q.cnt == `EAC_CNT_W'(WRITE_OSC_CYCLES - 1)) begin
                        s_d.phase = EAC_IDLE;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt + `EAC_CNT_W'(1);
                    end
                end else begin
                    s_d.div = s_q.div + `EAC_DIV_W'(1);
                end
            end
            default: begin
                s_d.phase = EAC_IDLE;
            end
        endcase
    end

    // only power-on clears it, so a system reset lets a write finish
    always_ff @(posedge clock or posedge por_rst) begin
        if (por_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.phase == EAC_PROG);
    assign done = s_q.done;
endmodule
`default_nettype wire

// ### eac_cell_array.sv
// byte array behind the access control, with the pending write latch
`timescale 1ns/100ps
`default_nettype none
`include "eac_defines.svh"
module eac_cell_array
    import eac_pkg::*;
(
    // clock
    input wire logic clock,
    // register side
    eac_nvm_if.array nvm
);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [7:0] mem [`EAC_MEM_BYTES]; // nonvolatile, never reset
    eac_array_state_type s_q; // registered state
    eac_array_state_type s_d; // next state

    // latch address and data when a write begins
    always_comb begin
        s_d = s_q;
        if (nvm.wr_start) begin
            s_d.pend_addr = nvm.addr;
            s_d.pend_data = nvm.wdata;
        end
        if (nvm.rd_en) begin
            s_d.rdata = mem[nvm.addr];
        end
    end

    // no reset: contents must survive a reset mid write
    always_ff @(posedge clock) begin
        s_q <= s_d;
    end

    // byte lands when the write time has elapsed
    always_ff @(posedge clock) begin
        if (nvm.wr_done) begin
            mem[s_q.pend_addr] <= s_q.pend_data;
        end
    end

    assign nvm.rdata = s_q.rdata;
endmodule
`default_nettype wire

// ### eac_core_model.sv
// core-side model that drives the i/o register port of the block
`timescale 1ns/100ps
`default_nettype none
`include "eac_defines.svh"
module eac_core_model
    import eac_pkg::*;
(
    // clock
    input wire logic clock,
    // i/o register port toward the block
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata,
    output logic io_we,
    output logic io_re,
    input wire logic [7:0] io_rdata
);
    // --------------------------------------------------------
    // bus idle at time zero
    // --------------------------------------------------------
    initial begin
        io_addr = 6'h00;
        io_wdata = 8'h00;
        io_we = 1'b0;
        io_re = 1'b0;
    end

    // one register write; the strobe drops for a cycle after it
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        io_addr <= a;
        io_wdata <= d;
        io_we <= 1'b1;
        @(posedge clock);
        io_we <= 1'b0;
    endtask

    // one register read; data is registered at the sampling edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock);
        io_addr <= a;
        io_re <= 1'b1;
        @(posedge clock);
        io_re <= 1'b0;
        #1;
        d = io_rdata;
    endtask

    // enable then strobe two cycles apart, well inside the window
    task automatic write_seq(input logic [7:0] keep);
        wr(`EAC_OFS_CTRL, keep | 8'h04);
        wr(`EAC_OFS_CTRL, keep | 8'h06);
    endtask
endmodule
`default_nettype wire

// ### eac_testbench.sv
// self-checking bench for the eeprom access control block
`timescale 1ns/100ps
`default_nettype none
`include "eac_defines.svh"
module testbench
    import eac_pkg::*;
;
    // shortened write time keeps the run brief
    localparam int unsigned OSC = 4;
    localparam int WR_CYC = OSC * `EAC_OSC_DIV;
    logic clock, rst, por, gie, spe, stall, irq, osc;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, v;
    logic io_we, io_re;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int t0;

    eac_top #(.WRITE_OSC_CYCLES(OSC)) uut (
        .clock(clock), .rst(rst), .por_rst(por),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
        .io_rdata(io_rdata), .global_irq_enable(gie), .self_program_enable(spe),
        .cpu_stall(stall), .ready_irq(irq), .osc_keep_running(osc)
    );
    eac_core_model core (
        .clock(clock), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata)
    );

    // --------------------------------------------------------
    // clock, cycle count, watchdog
    // --------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    initial begin
        repeat (5000) @(posedge clock);
        err_count++;
        test_done();
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // count stall cycles; caller steps just past the launching edge
    task automatic stall_run(input int exp);
        int n;
        n = 0;
        while (stall === 1'b1 && n < 10) begin
            n++;
            @(posedge clock);
            #1;
        end
        chk(8'(n), 8'(exp), "stall length");
    endtask

    // wait out a write; the tick divider restarts with each write, so the length is exact
    task automatic wait_idle();
        int n;
        n = 0;
        while (osc === 1'b1 && n < 300) begin
            n++;
            @(posedge clock);
            #1;
        end
        n = cyc - t0;
        n_tests++;
        if (n != WR_CYC) begin
            err_count++;
            $display("ERROR %0t: write took %0d cycles", $time, n);
        end
    endtask

    task automatic start_write(input logic [7:0] keep);
        core.write_seq(keep);
        #1;
        t0 = cyc;
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_regs();
        core.rd(`EAC_OFS_CTRL, v); chk(v, 8'h00, "ctrl reset");
        core.wr(`EAC_OFS_CTRL, 8'hf8);
        core.rd(`EAC_OFS_CTRL, v); chk(v, 8'h08, "ctrl reserved");
        core.wr(`EAC_OFS_ADDRH, 8'hff);
        core.rd(`EAC_OFS_ADDRH, v); chk(v, 8'h01, "addr high");
        core.wr(`EAC_OFS_CTRL, 8'h04);
        core.rd(`EAC_OFS_CTRL, v); chk(v, 8'h04, "enable set");
        repeat (2) @(posedge clock);
        core.rd(`EAC_OFS_CTRL, v); chk(v, 8'h00, "enable timeout");
        core.wr(`EAC_OFS_CTRL, 8'h02);
        repeat (2) @(posedge clock);
        #1 chk(8'(osc), 8'h00, "strobe alone");
        $display("test regs done");
    endtask

    task automatic t_write();
        core.wr(`EAC_OFS_ADDRH, 8'h01);
        core.wr(`EAC_OFS_ADDRL, 8'hab);
        core.wr(`EAC_OFS_DATA, 8'h5a);
        start_write(8'h00);
        stall_run(2);
        chk(8'(osc), 8'h01, "osc on");
        core.rd(`EAC_OFS_CTRL, v); chk(v, 8'h02, "strobe held");
        core.wr(`EAC_OFS_ADDRL, 8'h00);
        core.wr(`EAC_OFS_CTRL, 8'h01);
        core.write_seq(8'h00);
        core.rd(`EAC_OFS_DATA, v); chk(v, 8'h5a, "read while busy");
        wait_idle();
        core.rd(`EAC_OFS_CTRL, v); chk(v, 8'h00, "strobe cleared");
        core.rd(`EAC_OFS_ADDRL, v); chk(v, 8'hab, "addr frozen");
        chk(8'(osc), 8'h00, "no second write");
        core.wr(`EAC_OFS_DATA, 8'h00);
        core.wr(`EAC_OFS_CTRL, 8'h01);
        #1 stall_run(4);
        core.rd(`EAC_OFS_DATA, v); chk(v, 8'h5a, "read back");
        $display("test write done");
    endtask

    task automatic t_irq();
        core.wr(`EAC_OFS_CTRL, 8'h08);
        #1 chk(8'(irq), 8'h00, "irq without global");
        @(posedge clock);
        gie <= 1'b1;
        #1 chk(8'(irq), 8'h01, "irq level");
        start_write(8'h08);
        chk(8'(irq), 8'h00, "irq during write");
        wait_idle();
        chk(8'(irq), 8'h01, "irq after write");
        core.wr(`EAC_OFS_CTRL, 8'h00);
        #1 chk(8'(irq), 8'h00, "irq disabled");
        @(posedge clock);
        gie <= 1'b0;
        $display("test irq done");
    endtask

    task automatic t_spm();
        @(posedge clock);
        spe <= 1'b1;
        core.write_seq(8'h00);
        repeat (3) @(posedge clock);
        #1 chk(8'(osc), 8'h00, "blocked by flash");
        @(posedge clock);
        spe <= 1'b0;
        $display("test flash interlock done");
    endtask

    task automatic t_reset_mid();
        core.wr(`EAC_OFS_ADDRL, 8'h12);
        core.wr(`EAC_OFS_DATA, 8'hc3);
        start_write(8'h00);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1 chk(8'(osc), 8'h01, "write survives reset");
        wait_idle();
        // the reset cleared the address register, so the high bit is loaded again
        core.wr(`EAC_OFS_ADDRH, 8'h01);
        core.wr(`EAC_OFS_ADDRL, 8'h12);
        core.wr(`EAC_OFS_CTRL, 8'h01);
        core.rd(`EAC_OFS_DATA, v); chk(v, 8'hc3, "byte after reset");
        $display("test reset done");
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        rst = 1'b1;
        por = 1'b1;
        gie = 1'b0;
        spe = 1'b0;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        por <= 1'b0;
        t_regs();
        t_write();
        t_irq();
        t_spm();
        t_reset_mid();
        test_done();
    end
endmodule
`default_nettype wire
